//--- hdl/afe_pkg.sv
// Purpose: Shared constants for the front-end device end and its host end.
// Assumes: One 250 MHz clock; all pins sampled as synchronous inputs.
// Notes:   Field layout of the device configuration byte and host register map.
package afe_pkg;
   // Configuration byte field positions
   localparam int PRESCALE_LSB   = 0;
   localparam int OVERSAMP_LSB   = 2;
   localparam int MODEN_LSB      = 4;
   localparam int IDLE_DRIVE_BIT = 6;
   localparam int EXT_CLK_BIT    = 7;
   localparam logic [7:0] CONFIG_RESET = 8'h04;  // Prescale 1, ratio 64
   // Divider widths and fixed ratios
   localparam int PRE_W  = 3;
   localparam int QUAD_W = 2;
   localparam int RATE_W = 8;
   localparam logic [QUAD_W-1:0] QUAD_LIMIT = 2'h3;  // Analog clock over 4
   localparam logic [RATE_W-1:0] RATE_BASE  = 8'h20; // Ratio 32 for field 00
   // Serial framing
   localparam int CMD_READ_BIT = 0;               // Read flag inside command byte
   localparam int BYTE_BITS    = 8;
   localparam int MAX_BYTES    = 4;
   // Host register byte addresses
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CMD  = 4'h4;
   localparam logic [3:0] ADDR_DATA = 4'h8;
   // Host control bits
   localparam int CTRL_START = 0;
   localparam int CTRL_HRST  = 1;
   localparam int CTRL_CPOL  = 2;
   localparam int STAT_BUSY  = 8;
   localparam int COUNT_LSB  = 8;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   // Device serial states
   typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_WRITE, SER_READ} ser_state_type;
   // Host serial states
   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END} host_state_type;
endpackage : afe_pkg

//--- hdl/afe_link_if.sv
// Purpose: Pin bundle between the front-end device and its host.
// Assumes: Testbench reads the resolved lines; ends see only their own signals.
// Notes:   Resolution of three-state and pulled-up pins lives here only.
`timescale 1ns/1ps
interface afe_link_if;
   // Host driven pins
   logic hard_reset_n;
   logic cs_n;
   logic sck;
   logic sdi;
   logic osc_in_or_clock_in;
   // Device driven pins with enables
   logic sdo;
   logic sdo_oe;
   logic data_ready_n;
   logic data_ready_n_oe;
   logic mod_bitstream_out_ch0;
   logic mod_bitstream_out_ch0_oe;
   logic mod_bitstream_out_ch1;
   logic mod_bitstream_out_ch1_oe;
   logic osc_out;
   logic osc_out_oe;
   // Resolved wire levels
   wire  sdo_line;
   wire  data_ready_line;
   assign sdo_line        = sdo_oe ? sdo : !sdo;  // Released: inverse of last bit, so a stray sample shows
   assign data_ready_line = data_ready_n_oe ? data_ready_n : 1'b1;  // Pull-up
   modport device (
      input  hard_reset_n, cs_n, sck, sdi, osc_in_or_clock_in,
      output sdo, sdo_oe, data_ready_n, data_ready_n_oe,
      output mod_bitstream_out_ch0, mod_bitstream_out_ch0_oe,
      output mod_bitstream_out_ch1, mod_bitstream_out_ch1_oe, osc_out, osc_out_oe
   );
   modport host (
      output hard_reset_n, cs_n, sck, sdi, osc_in_or_clock_in,
      input  sdo_line, data_ready_line
   );
endinterface : afe_link_if

//--- hdl/rate_divider.sv
// Purpose: Enable-driven counter giving one tick every limit+1 enables.
// Assumes: clear is synchronous and overrides counting.
// Notes:   tick is combinational from the count and the enable.
`timescale 1ns/1ps
module rate_divider #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         reset,
   // Control
   input  wire logic         clear,
   input  wire logic         en,
   input  wire logic [W-1:0] limit,
   // Result
   output logic              tick
);
   logic [W-1:0] count_r;  // Enables seen since last tick

   // Tick when the last enable of a period arrives
   assign tick = en && (count_r >= limit);

   // Count enables, wrap at the limit
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         count_r <= '0;
      end else if (clear) begin
         count_r <= '0;
      end else if (tick) begin
         count_r <= '0;
      end else if (en) begin
         count_r <= count_r + 1'b1;
      end
   end
endmodule : rate_divider

//--- hdl/afe_device_end.sv
// Purpose: Pin logic of the converter front end: clock tree, ready pulse, modulator pins, serial port.
// Assumes: Pins arrive synchronous to clk; master clock pin far slower than clk.
// Notes:   Configuration byte loaded from user side; command/data bytes passed to user side.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module afe_device_end (
   // Clock and power-on reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Link pins
   afe_link_if.device       link,
   // Configuration load
   input  wire logic        cfg_write,
   input  wire logic [7:0]  cfg_data,
   // Modulator bits from the converters
   input  wire logic [1:0]  mod_bit_in,
   // Read data supply
   input  wire logic [7:0]  rd_data,
   // Serial results
   output logic             cmd_valid,
   output logic [7:0]       cmd_byte,
   output logic             wr_valid,
   output logic [7:0]       wr_data,
   output logic             rd_take,
   // Status
   output logic [7:0]       config_out,
   output logic             sample_tick,
   output logic             rate_tick
);
   import afe_pkg::*;

   logic [7:0]             primary_config_reg;  // Prescale, ratio, enables, idle drive, clock select
   logic                   hold;                // Hard reset pin low
   logic                   mclk_prev_r;         // Previous master clock pin level
   logic                   mclk_tick;           // Master clock rising edge
   logic                   analog_clock;        // Analog clock enable
   logic                   sample_clock;        // Sample clock enable
   logic                   output_rate_clock;   // Output rate enable
   logic [PRE_W-1:0]       pre_limit;           // Prescale terminal count
   logic [RATE_W-1:0]      ratio_limit;         // Oversampling terminal count
   logic                   sck_prev_r;          // Previous serial clock level
   logic                   cs_prev_r;           // Previous chip select level
   logic                   sck_rise;            // Serial clock rising edge in frame
   logic                   sck_fall;            // Serial clock falling edge in frame
   ser_state_type          state_r;             // Serial phase
   logic [2:0]             bit_cnt_r;           // Bits within current byte
   logic [7:0]             in_sh_r;             // Input shift register
   logic [7:0]             out_sh_r;            // Output shift register
   logic                   pulse_r;             // Ready pulse in progress
   logic                   pulse_nxt;           // Next ready pulse state

   assign hold = !link.hard_reset_n;

   // Field decode into divider limits
   assign pre_limit   = PRE_W'((1 << primary_config_reg[PRESCALE_LSB +: 2]) - 1);
   assign ratio_limit = RATE_W'((RATE_BASE << primary_config_reg[OVERSAMP_LSB +: 2]) - 1);

   // Configuration register, defaults while hard reset held
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         primary_config_reg <= CONFIG_RESET;
      end else if (hold) begin
         primary_config_reg <= CONFIG_RESET;
      end else if (cfg_write) begin
         primary_config_reg <= cfg_data;
      end
   end

   // Master clock pin edge detect; pin is crystal node or direct clock input
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mclk_prev_r <= 1'b0;
      end else begin
         mclk_prev_r <= link.osc_in_or_clock_in;
      end
   end
   assign mclk_tick = link.osc_in_or_clock_in && !mclk_prev_r && !hold;

   // Oscillator output: inverting amplifier in crystal mode, released in clock-input mode
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         link.osc_out    <= 1'b0;
         link.osc_out_oe <= 1'b0;
      end else begin
         link.osc_out    <= !link.osc_in_or_clock_in && !primary_config_reg[EXT_CLK_BIT];
         link.osc_out_oe <= !primary_config_reg[EXT_CLK_BIT] && !hold;
      end
   end

   // Clock tree dividers, cleared while hard reset held
   rate_divider #(.W(PRE_W)) u_prescale (
      .clk   (clk),
      .reset (reset),
      .clear (hold),
      .en    (mclk_tick),
      .limit (pre_limit),
      .tick  (analog_clock)
   );
   rate_divider #(.W(QUAD_W)) u_quarter (
      .clk   (clk),
      .reset (reset),
      .clear (hold),
      .en    (analog_clock),
      .limit (QUAD_LIMIT),
      .tick  (sample_clock)
   );
   rate_divider #(.W(RATE_W)) u_ratio (
      .clk   (clk),
      .reset (reset),
      .clear (hold),
      .en    (sample_clock),
      .limit (ratio_limit),
      .tick  (output_rate_clock)
   );

   // Rate ticks shown to the user side
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sample_tick <= 1'b0;
         rate_tick   <= 1'b0;
         config_out  <= CONFIG_RESET;
      end else begin
         sample_tick <= sample_clock;
         rate_tick   <= output_rate_clock;
         config_out  <= primary_config_reg;
      end
   end

   // Modulator pins refreshed once per sample period
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         link.mod_bitstream_out_ch0    <= 1'b0;
         link.mod_bitstream_out_ch1    <= 1'b0;
         link.mod_bitstream_out_ch0_oe <= 1'b0;
         link.mod_bitstream_out_ch1_oe <= 1'b0;
      end else begin
         if (sample_clock) begin
            link.mod_bitstream_out_ch0 <= mod_bit_in[0];
            link.mod_bitstream_out_ch1 <= mod_bit_in[1];
         end
         link.mod_bitstream_out_ch0_oe <= primary_config_reg[MODEN_LSB] && !hold;
         link.mod_bitstream_out_ch1_oe <= primary_config_reg[MODEN_LSB + 1] && !hold;
      end
   end

   // Ready pulse: starts on output-rate tick, ends at next sample tick; serial side never touches it
   always_comb begin
      pulse_nxt = pulse_r;
      if (hold) begin
         pulse_nxt = 1'b0;
      end else if (output_rate_clock) begin
         pulse_nxt = 1'b1;
      end else if (sample_clock) begin
         pulse_nxt = 1'b0;
      end
   end

   // Ready pin drive
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pulse_r              <= 1'b0;
         link.data_ready_n    <= 1'b1;
         link.data_ready_n_oe <= 1'b0;
      end else begin
         pulse_r              <= pulse_nxt;
         link.data_ready_n    <= !pulse_nxt;
         link.data_ready_n_oe <= pulse_nxt || primary_config_reg[IDLE_DRIVE_BIT];
      end
   end

   // Serial pin history
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sck_prev_r <= 1'b0;
         cs_prev_r  <= 1'b1;
      end else begin
         sck_prev_r <= link.sck;
         cs_prev_r  <= link.cs_n;
      end
   end
   assign sck_rise = link.sck && !sck_prev_r && !link.cs_n && !hold;
   assign sck_fall = !link.sck && sck_prev_r && !link.cs_n && !hold;

   // Serial phase machine
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r   <= SER_IDLE;
         bit_cnt_r <= '0;
         in_sh_r   <= '0;
      end else if (hold || link.cs_n) begin
         state_r   <= SER_IDLE;
         bit_cnt_r <= '0;
      end else begin
         unique case (state_r)
            SER_IDLE: begin
               if (cs_prev_r) begin
                  state_r   <= SER_CMD;
                  bit_cnt_r <= '0;
               end
            end
            SER_CMD, SER_WRITE: begin
               if (sck_rise) begin
                  in_sh_r   <= {in_sh_r[6:0], link.sdi};
                  bit_cnt_r <= bit_cnt_r + 1'b1;
                  if (bit_cnt_r == 3'(BYTE_BITS - 1) && state_r == SER_CMD) begin
                     state_r <= link.sdi ? SER_READ : SER_WRITE;
                  end
               end
            end
            SER_READ: begin
               if (sck_fall) begin
                  bit_cnt_r <= bit_cnt_r + 1'b1;
               end
            end
         endcase
      end
   end

   // Command and write-byte strobes
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cmd_valid <= 1'b0;
         cmd_byte  <= '0;
         wr_valid  <= 1'b0;
         wr_data   <= '0;
      end else begin
         cmd_valid <= 1'b0;
         wr_valid  <= 1'b0;
         if (sck_rise && bit_cnt_r == 3'(BYTE_BITS - 1) && !link.cs_n && !hold) begin
            if (state_r == SER_CMD) begin
               cmd_valid <= 1'b1;
               cmd_byte  <= {in_sh_r[6:0], link.sdi};
            end else if (state_r == SER_WRITE) begin
               wr_valid <= 1'b1;
               wr_data  <= {in_sh_r[6:0], link.sdi};
            end
         end
      end
   end

   // Read data out: changes on falling edges, whole bytes reloaded from the user side
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         out_sh_r    <= '0;
         link.sdo    <= 1'b0;
         link.sdo_oe <= 1'b0;
         rd_take     <= 1'b0;
      end else begin
         rd_take <= 1'b0;
         if (hold || link.cs_n || state_r != SER_READ) begin
            link.sdo_oe <= 1'b0;
         end else if (sck_fall) begin
            link.sdo_oe <= 1'b1;
            if (bit_cnt_r == '0) begin
               link.sdo <= rd_data[7];
               out_sh_r <= {rd_data[6:0], 1'b0};
               rd_take  <= 1'b1;
            end else begin
               link.sdo <= out_sh_r[7];
               out_sh_r <= {out_sh_r[6:0], 1'b0};
            end
         end
      end
   end
endmodule : afe_device_end

//--- hdl/afe_host_end.sv
// Purpose: Host controller driving the front end's serial pins, reset pin and master clock.
// Assumes: Software reaches it over Avalon-MM with waitrequest.
// Notes:   One transaction is a command byte plus 0..4 data bytes.
`timescale 1ns/1ps
module afe_host_end #(
   parameter int MCLK_HALF = 4,  // clk cycles per master clock half period
   parameter int SCK_HALF  = 4   // clk cycles per serial clock half period
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // Avalon-MM slave
   input  wire logic [3:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Link pins
   afe_link_if.host         link,
   // Status
   output logic             busy
);
   import afe_pkg::*;

   logic            hrst_r;       // Hard reset request from software
   logic            cpol_r;       // Serial clock idle level in use
   logic [15:0]     cmd_r;        // Command byte and data byte count
   logic [31:0]     txdata_r;     // Write bytes, first in bits 31:24
   logic [31:0]     rxdata_r;     // Read bytes gathered
   logic [39:0]     tx_sh_r;      // Outgoing bit stream
   logic [5:0]      bits_left_r;  // Rising edges still to make
   logic [5:0]      rd_skip_r;    // Rising edges before read data
   logic            is_read_r;    // Current command reads
   host_state_type  state_r;      // Transfer phase
   logic            mclk_tick;    // Master clock toggle enable
   logic            sck_tick;     // Serial clock half-period enable
   logic            take;         // Bus access accepted this edge
   logic            start;        // Software start request
   logic [5:0]      total_bits;   // Bits in a transaction

   assign take       = (read || write) && !waitrequest;
   assign start      = take && write && address == ADDR_CTRL && writedata[CTRL_START] && !busy && !hrst_r;
   assign total_bits = 6'(BYTE_BITS * (1 + int'(cmd_r[COUNT_LSB +: 3])));

   // Dividers for master clock and serial clock
   rate_divider #(.W(8)) u_mclk (
      .clk   (clk),
      .reset (reset),
      .clear (1'b0),
      .en    (1'b1),
      .limit (8'(MCLK_HALF - 1)),
      .tick  (mclk_tick)
   );
   rate_divider #(.W(8)) u_sck (
      .clk   (clk),
      .reset (reset),
      .clear (state_r == H_IDLE),
      .en    (1'b1),
      .limit (8'(SCK_HALF - 1)),
      .tick  (sck_tick)
   );

   // Master clock pin
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         link.osc_in_or_clock_in <= 1'b0;
      end else if (mclk_tick) begin
         link.osc_in_or_clock_in <= !link.osc_in_or_clock_in;
      end
   end

   // Bus handshake: one wait cycle, answer at the edge waitrequest is seen low
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         waitrequest <= 1'b1;
         readdata    <= '0;
      end else if ((read || write) && waitrequest) begin
         waitrequest <= 1'b0;
         unique case (address)
            ADDR_CTRL: readdata <= 32'({busy, 5'h00, cpol_r, hrst_r, 1'b0});
            ADDR_CMD:  readdata <= 32'(cmd_r);
            ADDR_DATA: readdata <= rxdata_r;
            default:   readdata <= UNMAPPED_READ;
         endcase
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // Software registers; idle level latched only while hard reset held
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         hrst_r   <= 1'b0;
         cpol_r   <= 1'b0;
         cmd_r    <= '0;
         txdata_r <= '0;
      end else if (take && write) begin
         if (address == ADDR_CTRL) begin
            hrst_r <= writedata[CTRL_HRST];
            if (hrst_r) begin
               cpol_r <= writedata[CTRL_CPOL];
            end
         end else if (address == ADDR_CMD && !busy) begin
            cmd_r <= writedata[15:0];
         end else if (address == ADDR_DATA && !busy) begin
            txdata_r <= writedata;
         end
      end
   end

   // Hard reset pin
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         link.hard_reset_n <= 1'b0;
      end else begin
         link.hard_reset_n <= !hrst_r;
      end
   end

   // Serial transfer engine
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         state_r     <= H_IDLE;
         link.cs_n   <= 1'b1;
         link.sck    <= 1'b0;
         link.sdi    <= 1'b0;
         tx_sh_r     <= '0;
         bits_left_r <= '0;
         rd_skip_r   <= '0;
         is_read_r   <= 1'b0;
         rxdata_r    <= '0;
         busy        <= 1'b0;
      end else begin
         unique case (state_r)
            H_IDLE: begin
               link.sck <= cpol_r;
               if (start) begin
                  state_r     <= H_SHIFT;
                  busy        <= 1'b1;
                  link.cs_n   <= 1'b0;
                  tx_sh_r     <= {cmd_r[7:0], txdata_r};
                  link.sdi    <= cmd_r[7];
                  bits_left_r <= total_bits;
                  rd_skip_r   <= 6'(BYTE_BITS);
                  is_read_r   <= cmd_r[CMD_READ_BIT];
                  rxdata_r    <= '0;
               end
            end
            H_SHIFT: begin
               if (sck_tick) begin
                  link.sck <= !link.sck;
                  if (!link.sck) begin
                     tx_sh_r     <= {tx_sh_r[38:0], 1'b0};
                     bits_left_r <= bits_left_r - 1'b1;
                     if (rd_skip_r != '0) begin
                        rd_skip_r <= rd_skip_r - 1'b1;
                     end else if (is_read_r) begin
                        rxdata_r <= {rxdata_r[30:0], link.sdo_line};
                     end
                     if (bits_left_r == 6'h01) begin
                        state_r <= H_END;
                     end
                  end else begin
                     link.sdi <= tx_sh_r[39];
                  end
               end
            end
            H_END: begin
               if (sck_tick) begin
                  if (link.sck != cpol_r) begin
                     link.sck <= cpol_r;
                  end else begin
                     link.cs_n <= 1'b1;
                     busy      <= 1'b0;
                     state_r   <= H_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule : afe_host_end

//--- verif/afe_monitor.sv
// Purpose: Assertions on the link pins between host end and device end.
// Assumes: SCK_HALF of 4 and MCLK_HALF of 2.
// Notes:   Watches the link signals only.
`timescale 1ns/1ps
module afe_monitor (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Host pins
   input wire logic hard_reset_n,
   input wire logic cs_n,
   input wire logic sck,
   // Device pins
   input wire logic sdo,
   input wire logic sdo_oe,
   input wire logic data_ready_n,
   input wire logic mod_bitstream_out_ch0_oe,
   input wire logic mod_bitstream_out_ch1_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [3:0] rises_r;  // Serial clock rises in this frame
   logic       sck_q;    // Serial clock one cycle ago
   // Count rises inside a frame, saturating
   always_ff @(posedge clk or posedge reset) begin
      if (reset) rises_r <= 4'h0;
      else if (cs_n) rises_r <= 4'h0;
      else if (sck && !sck_q && rises_r != 4'hF) rises_r <= rises_r + 4'h1;
   end
   // Serial clock history for the rise count
   always_ff @(posedge clk or posedge reset) begin
      if (reset) sck_q <= 1'b0;
      else sck_q <= sck;
   end
   sdo_float_a: assert property (cs_n && $past(cs_n) |-> !sdo_oe)
      else $error("sdo driven outside frame");
   hrst_quiet_a: assert property (!$past(hard_reset_n) |->
      !(sdo_oe || mod_bitstream_out_ch0_oe || mod_bitstream_out_ch1_oe)) else $error("pins driven in hard reset");
   cmd_first_a: assert property ($rose(sdo_oe) |-> rises_r >= 4'h8)
      else $error("sdo driven inside command byte");
   sdo_edge_a: assert property (sdo_oe && $changed(sdo) |-> !sck)
      else $error("sdo changed while sck high");
   ready_width_a: assert property ($fell(data_ready_n) |=> (!data_ready_n || !hard_reset_n) [*8])
      else $error("ready pulse too short");
   ready_gap_a: assert property ($rose(data_ready_n) |=> data_ready_n [*8])
      else $error("ready pulses too close");
   sck_idle_a: assert property (cs_n && $past(cs_n) && hard_reset_n && $past(hard_reset_n) |-> $stable(sck))
      else $error("serial clock moved outside frame");
   hrst_ready_a: assert property (!hard_reset_n |=> data_ready_n)
      else $error("ready pulse during hard reset");
endmodule : afe_monitor

//--- verif/afe_clock_tree_and_host_pins_bench.sv
// Purpose: Self-checking bench joining host end and device end.
// Assumes: MCLK_HALF of 2, so a sample period is 16 clk per prescale step.
// Notes:   Rate rows first, then serial, mode and hard reset cases.
`timescale 1ns/1ps
module afe_clock_tree_and_host_pins_bench;
   import afe_pkg::*;
   typedef struct {logic [7:0] cfg; int width;} row_type;
   // Each row gives a period of 4096 clk; widths follow the prescale
   row_type rows [4] = '{'{8'h7C, 16}, '{8'hF9, 32}, '{8'h76, 64}, '{8'hF3, 128}};
   logic clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, cfg_write = 1'b0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic waitrequest, busy, cmd_valid, wr_valid, rd_take, sample_tick, rate_tick;
   logic [7:0] cfg_data = 8'h00, rd_data = 8'h3C, cmd_byte, wr_data, config_out, got_wr = 8'h00;
   int n_mismatch = 0, n_compared = 0, n_cmd = 0, w, p;
   afe_link_if link ();
   always #2 clk = ~clk;
   afe_host_end #(.MCLK_HALF(2), .SCK_HALF(4)) afe_host_end_inst (.clk(clk), .reset(reset), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .link(link.host), .busy(busy));
   afe_device_end afe_device_end_inst (.clk(clk), .reset(reset), .link(link.device), .cfg_write(cfg_write),
      .cfg_data(cfg_data), .mod_bit_in(2'h2), .rd_data(rd_data), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
      .wr_valid(wr_valid), .wr_data(wr_data), .rd_take(rd_take), .config_out(config_out),
      .sample_tick(sample_tick), .rate_tick(rate_tick));
   afe_monitor afe_monitor_inst (.clk(clk), .reset(reset), .hard_reset_n(link.hard_reset_n), .cs_n(link.cs_n),
      .sck(link.sck), .sdo(link.sdo), .sdo_oe(link.sdo_oe), .data_ready_n(link.data_ready_n),
      .mod_bitstream_out_ch0_oe(link.mod_bitstream_out_ch0_oe), .mod_bitstream_out_ch1_oe(link.mod_bitstream_out_ch1_oe));
   // Record device results
   always @(posedge clk) begin
      if (cmd_valid === 1'b1) n_cmd++;
      if (wr_valid === 1'b1) got_wr <= wr_data;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   // One Avalon access, held until waitrequest is seen low
   task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
      @(posedge clk);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic xfer(input logic [7:0] c, input logic [2:0] n, input logic [31:0] d, input logic [31:0] ctl);
      bus(ADDR_DATA, 1'b1, d);
      bus(ADDR_CMD, 1'b1, {21'h0, n, c});
      bus(ADDR_CTRL, 1'b1, ctl);
      while (busy !== 1'b1) @(posedge clk);
      while (busy !== 1'b0) @(posedge clk);
   endtask : xfer
   task automatic fall();
      while (link.data_ready_line !== 1'b1) @(posedge clk);
      while (link.data_ready_line !== 1'b0) @(posedge clk);
   endtask : fall
   task automatic test_done();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   // Watchdog
   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk(32'({link.sdo_oe, link.data_ready_n_oe, link.mod_bitstream_out_ch0_oe, link.mod_bitstream_out_ch1_oe}), 0);
      chk(config_out, CONFIG_RESET);
      for (int i = 0; i < 4; i++) begin
         fall();
         while (link.data_ready_line !== 1'b1) @(posedge clk);
         cfg_write <= 1'b1;
         cfg_data <= rows[i].cfg;
         @(posedge clk);
         cfg_write <= 1'b0;
         fall();
         fall();
         chk({rate_tick, sample_tick}, 2'h3);
         for (w = 0; link.data_ready_line === 1'b0; w++) @(posedge clk);
         for (p = w; link.data_ready_line !== 1'b0; p++) @(posedge clk);
         chk(w, rows[i].width);
         chk(p, 4096);
         chk(link.osc_out_oe, !rows[i].cfg[7]);
         chk(link.mod_bitstream_out_ch0_oe & link.mod_bitstream_out_ch1_oe & link.data_ready_n_oe, 1);
         chk({link.mod_bitstream_out_ch1, link.mod_bitstream_out_ch0}, 2'h2);
         $display("rate row %0d done", i);
      end
      xfer(8'h42, 3'h1, 32'hA5000000, 32'h1);
      chk(got_wr, 8'hA5);
      xfer(8'h43, 3'h2, 32'hFF000000, 32'h1);
      bus(ADDR_DATA, 1'b0, 0);
      chk(q[15:0], 16'h3C3C);
      chk({n_cmd[7:0], got_wr}, {8'd2, 8'hA5});
      $display("serial test done");
      bus(ADDR_CTRL, 1'b1, 32'h2);
      bus(ADDR_CTRL, 1'b1, 32'h6);
      bus(ADDR_CTRL, 1'b1, 32'h4);
      rd_data <= 8'h96;
      xfer(8'h43, 3'h1, 32'h0, 32'h1);
      bus(ADDR_DATA, 1'b0, 0);
      chk(q[7:0], 8'h96);
      chk(cmd_byte, 8'h43);
      $display("mode test done");
      cfg_write <= 1'b1;
      cfg_data <= 8'h7C;
      @(posedge clk);
      cfg_write <= 1'b0;
      xfer(8'h42, 3'h1, 32'h0, 32'h3);
      chk({n_cmd[7:0], config_out, 7'h0, link.cs_n, link.data_ready_line}, {8'd3, CONFIG_RESET, 9'h3});
      bus(4'hC, 1'b1, 32'hFFFFFFFF);
      bus(4'hC, 1'b0, 0);
      chk(q, UNMAPPED_READ);
      $display("reset test done");
      test_done();
   end
endmodule : afe_clock_tree_and_host_pins_bench
